// [rtl/cpu_core.sv]
`timescale 1ns/1ps
`include "core_map.svh"

// Functional notes
// - Program fetch and data access buses independent.
// - Next word prefetched while current one executes.
// - ALU: register-register, register-immediate, single-register operations.
// - Arithmetic results update the status flags.
// - Thirty-two 8-bit registers, single-cycle access.
// - Six registers pair into three 16-bit pointers.
// - Program bus reaches Flash from word 0x0000.
// - I/O space is lowest 4KB of data.
// - Direct I/O reaches 64 locations at 0x00-0x3F.
// - Low I/O also reachable by load and store.
// - Lowest 32 I/O: bit set, clear, skip.
// - Extended I/O 0x0040-0x0FFF via load/store only.
// - 0x1000-0x17FF maps fuses, NVM controller, EEPROM.
// - 0x1800-0x7FFF holds SRAM and other memories.
// - Flash readable in data space from 0x8000.
// - Program memory load uses code-space address.
// - Data addresses cover one 64KB space.
// - 16-bit accesses move both bytes together.
// - Fetch starts at program address 0x0000 after reset.
// - 8x8 multiply gives 16 bits in two cycles.

module cpu_core #(
  parameter logic [15:0] SRAM_BYTES  = `SRAM_SIZE_DEF,
  parameter logic [15:0] FLASH_BYTES = `FLASH_WIN_DEF
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Program memory bus
  output      logic [15:0]        pmem_addr,
  input  wire logic [15:0]        pmem_rdata,
  // Data space bus
  output      core_pkg::dreq_t    dreq,
  input  wire core_pkg::rdata_t   drdata,
  // Core status
  output      logic [3:0]         status_flags
);

  // --------------------------------------------------------------------------
  // State and decode signals
  // --------------------------------------------------------------------------
  core_pkg::core_state_t q;
  core_pkg::core_state_t d;
  core_pkg::opcode_t     op;
  logic [15:0]           req_addr;
  core_pkg::region_t     req_region;
  logic [15:0]           req_offset;
  core_pkg::alu_op_t     alu_op;
  logic [7:0]            alu_a;
  logic [7:0]            alu_b;
  logic [7:0]            alu_res;
  logic [3:0]            alu_flags;
  logic [4:0]            alu_dst;
  logic                  alu_wb;
  logic [4:0]            imm_reg;

  assign op      = core_pkg::opcode_t'(q.instr[`FLD_OP]);
  assign imm_reg = `IMM_REG_BASE | {1'b0, q.instr[`FLD_IRD]};

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic [4:0] ptr_low(input logic [1:0] sel);
    case (core_pkg::ptr_sel_t'(sel))
      core_pkg::PSEL_X: return `PTR_X;
      core_pkg::PSEL_Y: return `PTR_Y;
      default:          return `PTR_Z;
    endcase
  endfunction

  function automatic logic [15:0] ptr_value(input logic [31:0][7:0] regs, input logic [1:0] sel);
    logic [4:0] lo;
    lo = ptr_low(sel);
    return {regs[lo | 5'h01], regs[lo]};
  endfunction

  function automatic logic [15:0] sel_rdata(input core_pkg::region_t region, input core_pkg::rdata_t rd);
    case (region)
      core_pkg::REG_IO:    return rd.io;
      core_pkg::REG_NVM:   return rd.nvm;
      core_pkg::REG_SRAM:  return rd.sram;
      core_pkg::REG_FLASH: return rd.flash;
      default:             return 16'h0000;
    endcase
  endfunction

  // A write into the Flash window or into a hole selects no target, so it simply vanishes.
  function automatic core_pkg::dreq_t make_req(input core_pkg::region_t region, input logic [15:0] offset,
                                               input logic rd, input logic wr, input logic wide,
                                               input logic [15:0] wdata, input logic [7:0] wmask);
    core_pkg::dreq_t r;
    r           = '0;
    r.addr      = offset;
    r.wdata     = wdata;
    r.wmask     = wmask;
    r.wide      = wide;
    r.rd        = rd;
    r.wr        = wr;
    r.sel.io    = (region == core_pkg::REG_IO);
    r.sel.nvm   = (region == core_pkg::REG_NVM);
    r.sel.sram  = (region == core_pkg::REG_SRAM);
    r.sel.flash = (region == core_pkg::REG_FLASH) && rd;
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Data address formation and decode
  // --------------------------------------------------------------------------
  always_comb begin
    case (op)
      core_pkg::OP_IO:    req_addr = {10'h000, q.instr[`FLD_IOA]};
      core_pkg::OP_IOBIT: req_addr = {11'h000, q.instr[`FLD_BA]};
      default:            req_addr = ptr_value(q.regs, q.instr[`FLD_PTR]);
    endcase
  end

  // The full 16-bit address goes to the decoder, so one map spans all 64KB.
  data_space_decoder #(
    .SRAM_BYTES  (SRAM_BYTES),
    .FLASH_BYTES (FLASH_BYTES)
  ) u_decode (
    .addr   (req_addr),
    .region (req_region),
    .offset (req_offset)
  );

  // --------------------------------------------------------------------------
  // ALU operand selection
  // --------------------------------------------------------------------------
  always_comb begin
    alu_a   = q.regs[q.instr[`FLD_RD]];
    alu_b   = q.regs[q.instr[`FLD_RR]];
    alu_dst = q.instr[`FLD_RD];
    alu_op  = core_pkg::ALU_PASS;
    alu_wb  = 1'b0;
    if (q.valid && (q.state == core_pkg::ST_EXEC)) begin
      case (op)
        core_pkg::OP_ADD: begin
          alu_op = core_pkg::ALU_ADD;
          alu_wb = 1'b1;
        end
        core_pkg::OP_SUB: begin
          alu_op = core_pkg::ALU_SUB;
          alu_wb = 1'b1;
        end
        core_pkg::OP_AND: begin
          alu_op = core_pkg::ALU_AND;
          alu_wb = 1'b1;
        end
        core_pkg::OP_OR: begin
          alu_op = core_pkg::ALU_OR;
          alu_wb = 1'b1;
        end
        core_pkg::OP_XOR: begin
          alu_op = core_pkg::ALU_XOR;
          alu_wb = 1'b1;
        end
        core_pkg::OP_MOV: begin
          alu_wb = 1'b1;
        end
        core_pkg::OP_LDI, core_pkg::OP_SUBI, core_pkg::OP_ANDI, core_pkg::OP_ORI: begin
          alu_a   = q.regs[imm_reg];
          alu_b   = q.instr[`FLD_IMM];
          alu_dst = imm_reg;
          alu_wb  = 1'b1;
          case (op)
            core_pkg::OP_SUBI: alu_op = core_pkg::ALU_SUB;
            core_pkg::OP_ANDI: alu_op = core_pkg::ALU_AND;
            core_pkg::OP_ORI:  alu_op = core_pkg::ALU_OR;
            default:           alu_op = core_pkg::ALU_PASS;
          endcase
        end
        core_pkg::OP_UNARY: begin
          alu_wb = 1'b1;
          case (core_pkg::unary_fn_t'(q.instr[`FLD_UFN]))
            core_pkg::UN_INC: alu_op = core_pkg::ALU_INC;
            core_pkg::UN_DEC: alu_op = core_pkg::ALU_DEC;
            core_pkg::UN_COM: alu_op = core_pkg::ALU_COM;
            core_pkg::UN_NEG: alu_op = core_pkg::ALU_NEG;
            core_pkg::UN_LSR: alu_op = core_pkg::ALU_LSR;
            default: begin
              alu_op = core_pkg::ALU_PASS;
              alu_wb = 1'b0;
            end
          endcase
        end
        default: begin
          alu_wb = 1'b0;
        end
      endcase
    end
  end

  core_alu u_alu (
    .op        (alu_op),
    .a         (alu_a),
    .b         (alu_b),
    .flags_in  (q.flags),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [15:0] rdata;
    logic [15:0] ptr;
    logic [4:0]  lo;
    logic [4:0]  rd_even;
    logic        wide;
    rdata   = sel_rdata(q.region, drdata);
    ptr     = ptr_value(q.regs, q.instr[`FLD_PTR]);
    lo      = ptr_low(q.instr[`FLD_PTR]);
    rd_even = q.instr[`FLD_MRD] & ~5'h01;
    wide    = q.instr[`FLD_WIDE];
    d          = q;
    d.dreq.rd  = 1'b0;
    d.dreq.wr  = 1'b0;
    d.dreq.sel = '0;
    case (q.state)
      core_pkg::ST_EXEC: begin
        // Fetch of the next word runs alongside execution; a load, skip or multiply stall holds the fetch address, a program-memory load redirects it.
        d.instr   = pmem_rdata;
        d.valid   = 1'b1;
        d.exec_pc = q.fetch;
        d.fetch   = q.fetch + 16'h0001;
        if (alu_wb) begin
          d.regs[alu_dst] = alu_res;
          d.flags         = alu_flags;
        end
        if (q.valid) begin
          case (op)
            core_pkg::OP_JUMP: begin
              d.fetch = q.exec_pc + 16'h0001 + {{4{q.instr[`FLD_JSIGN]}}, q.instr[`FLD_JOFF]};
              d.valid = 1'b0;
            end
            core_pkg::OP_MUL: begin
              d.prod  = {8'h00, q.regs[q.instr[`FLD_RD]]} * {8'h00, q.regs[q.instr[`FLD_RR]]};
              d.state = core_pkg::ST_MUL;
            end
            core_pkg::OP_IO: begin
              if (q.instr[`FLD_IODIR]) begin
                d.dreq = make_req(req_region, req_offset, 1'b0, 1'b1, 1'b0,
                                  {8'h00, q.regs[q.instr[`FLD_IORD]]}, 8'hFF);
              end else begin
                d.dreq      = make_req(req_region, req_offset, 1'b1, 1'b0, 1'b0, 16'h0000, 8'hFF);
                d.region    = req_region;
                d.pend_rd   = q.instr[`FLD_IORD];
                d.pend_wide = 1'b0;
                d.state     = core_pkg::ST_LOAD;
              end
            end
            core_pkg::OP_IOBIT: begin
              // A masked write keeps bit set and clear to one cycle with no read-back.
              case (core_pkg::bit_fn_t'(q.instr[`FLD_BFN]))
                core_pkg::BIT_SET: d.dreq = make_req(req_region, req_offset, 1'b0, 1'b1, 1'b0, 16'h00FF,
                                                     8'h01 << q.instr[`FLD_BB]);
                core_pkg::BIT_CLR: d.dreq = make_req(req_region, req_offset, 1'b0, 1'b1, 1'b0, 16'h0000,
                                                     8'h01 << q.instr[`FLD_BB]);
                default: begin
                  d.dreq     = make_req(req_region, req_offset, 1'b1, 1'b0, 1'b0, 16'h0000, 8'hFF);
                  d.region   = req_region;
                  d.pend_bit = q.instr[`FLD_BB];
                  d.pend_set = (q.instr[`FLD_BFN] == core_pkg::BIT_SKIP_SET);
                  d.state    = core_pkg::ST_SKIP;
                end
              endcase
            end
            core_pkg::OP_MEM: begin
              if (q.instr[`FLD_PTR] == core_pkg::PSEL_PROG) begin
                if (!q.instr[`FLD_STORE]) begin
                  d.fetch    = {1'b0, ptr[15:1]};
                  d.resume   = q.fetch + 16'h0001;
                  d.pend_rd  = q.instr[`FLD_MRD];
                  d.pend_bit = {2'b00, ptr[0]};
                  d.state    = core_pkg::ST_PMLOAD;
                  if (q.instr[`FLD_INC]) begin
                    {d.regs[lo | 5'h01], d.regs[lo]} = ptr + 16'h0001;
                  end
                end
              end else begin
                if (q.instr[`FLD_STORE]) begin
                  d.dreq = make_req(req_region, req_offset, 1'b0, 1'b1, wide,
                                    wide ? {q.regs[rd_even | 5'h01], q.regs[rd_even]}
                                         : {8'h00, q.regs[q.instr[`FLD_MRD]]}, 8'hFF);
                end else begin
                  d.dreq      = make_req(req_region, req_offset, 1'b1, 1'b0, wide, 16'h0000, 8'hFF);
                  d.region    = req_region;
                  d.pend_rd   = q.instr[`FLD_MRD];
                  d.pend_wide = wide;
                  d.state     = core_pkg::ST_LOAD;
                end
                if (q.instr[`FLD_INC]) begin
                  {d.regs[lo | 5'h01], d.regs[lo]} = ptr + (wide ? 16'h0002 : 16'h0001);
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      core_pkg::ST_LOAD: begin
        // Both bytes of a wide read land in the pair at once, so a 16-bit value is never torn.
        if (q.pend_wide) begin
          d.regs[{q.pend_rd[4:1], 1'b0}] = rdata[7:0];
          d.regs[{q.pend_rd[4:1], 1'b1}] = rdata[15:8];
        end else begin
          d.regs[q.pend_rd] = rdata[7:0];
        end
        d.state = core_pkg::ST_EXEC;
      end
      core_pkg::ST_SKIP: begin
        if (rdata[q.pend_bit] == q.pend_set) begin
          d.valid = 1'b0;
        end
        d.state = core_pkg::ST_EXEC;
      end
      core_pkg::ST_PMLOAD: begin
        d.regs[q.pend_rd] = q.pend_bit[0] ? pmem_rdata[15:8] : pmem_rdata[7:0];
        d.fetch           = q.resume;
        d.state           = core_pkg::ST_EXEC;
      end
      core_pkg::ST_MUL: begin
        d.regs[`MUL_LO]          = q.prod[7:0];
        d.regs[`MUL_LO | 5'h01]  = q.prod[15:8];
        d.flags[`FLAG_C]         = q.prod[15];
        d.flags[`FLAG_Z]         = (q.prod == 16'h0000);
        d.state                  = core_pkg::ST_EXEC;
      end
      default: begin
        d.state = core_pkg::ST_EXEC;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register and outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q       <= '0;
      q.fetch <= `RESET_PC;
    end else begin
      q <= d;
    end
  end

  // Fetch and data requests come from separate fields, so both can be active in one cycle.
  assign pmem_addr    = q.fetch;
  assign dreq         = q.dreq;
  assign status_flags = q.flags;

endmodule // cpu_core

// [rtl/core_map.svh]
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH

// ----------------------------------------------------------------------------
// Data space layout
// ----------------------------------------------------------------------------
`define IO_END        16'h0FFF
`define NVM_BASE      16'h1000
`define MEM_BASE      16'h1800
`define FLASH_BASE    16'h8000
`define SRAM_SIZE_DEF 16'h6800
`define FLASH_WIN_DEF 16'h8000

// ----------------------------------------------------------------------------
// Reset and fixed register roles
// ----------------------------------------------------------------------------
`define RESET_PC      16'h0000
`define PTR_X         5'h1A
`define PTR_Y         5'h1C
`define PTR_Z         5'h1E
`define MUL_LO        5'h00
`define IMM_REG_BASE  5'h10

// ----------------------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------------------
`define FLD_OP        15:12
`define FLD_JOFF      11:0
`define FLD_JSIGN     11
`define FLD_RD        9:5
`define FLD_RR        4:0
`define FLD_IRD       11:8
`define FLD_IMM       7:0
`define FLD_UFN       2:0
`define FLD_IODIR     11
`define FLD_IORD      10:6
`define FLD_IOA       5:0
`define FLD_BFN       11:10
`define FLD_BA        7:3
`define FLD_BB        2:0
`define FLD_STORE     11
`define FLD_PTR       10:9
`define FLD_MRD       8:4
`define FLD_INC       1
`define FLD_WIDE      0

// ----------------------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------------------
`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_V        3

`endif

// [rtl/core_pkg.sv]
package core_pkg;

  typedef enum logic [3:0] {
    OP_JUMP = 4'h0, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV, OP_MUL,
    OP_LDI, OP_SUBI, OP_ANDI, OP_ORI, OP_UNARY, OP_IO, OP_IOBIT, OP_MEM
  } opcode_t;

  typedef enum logic [2:0] {
    UN_INC = 3'h0, UN_DEC, UN_COM, UN_NEG, UN_LSR
  } unary_fn_t;

  typedef enum logic [1:0] {
    BIT_SET = 2'h0, BIT_CLR, BIT_SKIP_SET, BIT_SKIP_CLR
  } bit_fn_t;

  typedef enum logic [1:0] {
    PSEL_X = 2'h0, PSEL_Y, PSEL_Z, PSEL_PROG
  } ptr_sel_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_INC, ALU_DEC, ALU_COM, ALU_NEG, ALU_LSR
  } alu_op_t;

  typedef enum logic [2:0] {REG_NONE, REG_IO, REG_NVM, REG_SRAM, REG_FLASH} region_t;

  typedef enum logic [2:0] {ST_EXEC, ST_LOAD, ST_SKIP, ST_PMLOAD, ST_MUL} state_t;

  typedef struct packed {
    logic io;
    logic nvm;
    logic sram;
    logic flash;
  } sel_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [7:0]  wmask;
    logic        wide;
    logic        rd;
    logic        wr;
    sel_t        sel;
  } dreq_t;

  typedef struct packed {
    logic [15:0] io;
    logic [15:0] nvm;
    logic [15:0] sram;
    logic [15:0] flash;
  } rdata_t;

  typedef struct packed {
    logic [31:0][7:0] regs;
    logic [3:0]       flags;
    logic [15:0]      fetch;
    logic [15:0]      instr;
    logic             valid;
    logic [15:0]      exec_pc;
    logic [15:0]      resume;
    state_t           state;
    logic [4:0]       pend_rd;
    logic             pend_wide;
    logic [2:0]       pend_bit;
    logic             pend_set;
    logic [15:0]      prod;
    region_t          region;
    dreq_t            dreq;
  } core_state_t;

endpackage

// [rtl/data_space_decoder.sv]
`timescale 1ns/1ps
`include "core_map.svh"

module data_space_decoder #(
  parameter logic [15:0] SRAM_BYTES  = `SRAM_SIZE_DEF,
  parameter logic [15:0] FLASH_BYTES = `FLASH_WIN_DEF
) (
  // Data space address
  input  wire logic [15:0]        addr,
  // Decoded target
  output      core_pkg::region_t  region,
  output      logic [15:0]        offset
);

  always_comb begin
    region = core_pkg::REG_NONE;
    offset = addr;
    if (addr <= `IO_END) begin
      region = core_pkg::REG_IO;
    end else if (addr < `MEM_BASE) begin
      region = core_pkg::REG_NVM;
      offset = addr - `NVM_BASE;
    end else if (addr < `FLASH_BASE) begin
      offset = addr - `MEM_BASE;
      if (offset < SRAM_BYTES) begin
        region = core_pkg::REG_SRAM;
      end
    end else begin
      offset = addr - `FLASH_BASE;
      if (offset < FLASH_BYTES) begin
        region = core_pkg::REG_FLASH;
      end
    end
  end

endmodule // data_space_decoder

// [rtl/core_alu.sv]
`timescale 1ns/1ps
`include "core_map.svh"

module core_alu (
  // Operation
  input  wire core_pkg::alu_op_t  op,
  // Operands and incoming flags
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  input  wire logic [3:0]         flags_in,
  // Result and updated flags
  output      logic [7:0]         result,
  output      logic [3:0]         flags_out
);

  logic [8:0] wide;

  always_comb begin
    case (op)
      core_pkg::ALU_ADD:  wide = {1'b0, a} + {1'b0, b};
      core_pkg::ALU_SUB:  wide = {1'b0, a} - {1'b0, b};
      core_pkg::ALU_AND:  wide = {1'b0, a & b};
      core_pkg::ALU_OR:   wide = {1'b0, a | b};
      core_pkg::ALU_XOR:  wide = {1'b0, a ^ b};
      core_pkg::ALU_INC:  wide = {1'b0, a} + 9'h001;
      core_pkg::ALU_DEC:  wide = {1'b0, a} - 9'h001;
      core_pkg::ALU_COM:  wide = {1'b1, ~a};
      core_pkg::ALU_NEG:  wide = 9'h000 - {1'b0, a};
      core_pkg::ALU_LSR:  wide = {a[0], 1'b0, a[7:1]};
      default:            wide = {1'b0, b};
    endcase
    result    = wide[7:0];
    flags_out = flags_in;
    // Moves and immediate loads leave the flags alone so they can be used between compare and branch.
    if (op != core_pkg::ALU_PASS) begin
      flags_out[`FLAG_Z] = (result == 8'h00);
      flags_out[`FLAG_N] = result[7];
      case (op)
        core_pkg::ALU_ADD:  flags_out[`FLAG_V] = (a[7] == b[7]) && (result[7] != a[7]);
        core_pkg::ALU_SUB:  flags_out[`FLAG_V] = (a[7] != b[7]) && (result[7] != a[7]);
        core_pkg::ALU_INC:  flags_out[`FLAG_V] = (result == 8'h80);
        core_pkg::ALU_DEC:  flags_out[`FLAG_V] = (result == 8'h7F);
        core_pkg::ALU_NEG:  flags_out[`FLAG_V] = (result == 8'h80);
        default:            flags_out[`FLAG_V] = 1'b0;
      endcase
      case (op)
        core_pkg::ALU_ADD, core_pkg::ALU_SUB, core_pkg::ALU_NEG, core_pkg::ALU_LSR,
        core_pkg::ALU_COM:  flags_out[`FLAG_C] = wide[8];
        default:            flags_out[`FLAG_C] = flags_in[`FLAG_C];
      endcase
    end
  end

endmodule // core_alu

// [bench/core_chk.sv]
`timescale 1ns/1ps
module core_chk #(
  parameter logic [15:0] SRAM_BYTES = 16'h6800
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Buses
  input  wire logic [15:0]      pmem_addr,
  input  wire logic [15:0]      pmem_rdata,
  input  wire core_pkg::dreq_t  dreq,
  input  wire core_pkg::rdata_t drdata,
  input  wire logic [3:0]       status_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_release; reset ##1 !reset; endsequence
  sequence s_pulse; dreq.rd ##1 !dreq.rd; endsequence
  a_fetch_at_zero: assert property (disable iff (1'b0) s_release |-> pmem_addr == 16'h0000)
    else $error("fetch not at word zero");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> dreq == '0 && status_flags == 4'h0)
    else $error("bus or flags active in reset");
  a_read_pulse: assert property (dreq.rd |-> s_pulse)
    else $error("read strobe longer than one cycle");
  a_sel_onehot: assert property ($onehot0(dreq.sel))
    else $error("two targets selected");
  a_sel_strobed: assert property (|dreq.sel |-> dreq.rd || dreq.wr)
    else $error("select without strobe");
  a_flash_ro: assert property (dreq.wr |-> !dreq.sel.flash)
    else $error("write reached flash window");
  a_io_span: assert property (dreq.sel.io |-> dreq.addr <= 16'h0FFF)
    else $error("io offset out of range");
  a_nvm_span: assert property (dreq.sel.nvm |-> dreq.addr < 16'h0800)
    else $error("nvm offset out of range");
  a_sram_span: assert property (dreq.sel.sram |-> dreq.addr < SRAM_BYTES)
    else $error("sram offset out of range");
endmodule // core_chk

bind cpu_core core_chk #(.SRAM_BYTES(SRAM_BYTES)) u_chk (
  .clk(clk), .reset(reset), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
  .dreq(dreq), .drdata(drdata), .status_flags(status_flags));

// [bench/mem_model.sv]
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire logic             clk,
  // Program bus
  input  wire logic [15:0]      pmem_addr,
  output      logic [15:0]      pmem_rdata,
  // Data bus
  input  wire core_pkg::dreq_t  dreq,
  output      core_pkg::rdata_t drdata
);
  logic [15:0] prog [256];
  logic [7:0]  dmem [65536];
  logic [15:0] a;
  logic [15:0] v;
  initial begin
    foreach (prog[i]) prog[i] = 16'h0000;
    foreach (dmem[i]) dmem[i] = 8'h00;
  end
  assign pmem_rdata = prog[pmem_addr[7:0]];
  // Unselected fields show the inverse, so a stale value never passes for an answer.
  always_comb begin
    a = dreq.addr + (dreq.sel.nvm ? 16'h1000 : dreq.sel.sram ? 16'h1800 : dreq.sel.flash ? 16'h8000 : 16'h0000);
    v = {dmem[a + 16'h0001], dmem[a]};
    drdata.io = (dreq.rd && dreq.sel.io) ? v : ~v;
    drdata.nvm = (dreq.rd && dreq.sel.nvm) ? v : ~v;
    drdata.sram = (dreq.rd && dreq.sel.sram) ? v : ~v;
    drdata.flash = (dreq.rd && dreq.sel.flash) ? v : ~v;
  end
  always @(posedge clk) begin
    if (dreq.wr && (|dreq.sel)) begin
      dmem[a] <= (dmem[a] & ~dreq.wmask) | (dreq.wdata[7:0] & dreq.wmask);
      if (dreq.wide) begin
        dmem[a + 16'h0001] <= dreq.wdata[15:8];
      end
    end
  end
endmodule // mem_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic             clk;
  logic             reset;
  logic [15:0]      pmem_addr;
  logic [15:0]      pmem_rdata;
  core_pkg::dreq_t  dreq;
  core_pkg::rdata_t drdata;
  logic [3:0]       status_flags;
  int               n_mismatch;
  int               n_checks;
  int               pc;
  logic [7:0]       x;
  logic [7:0]       y;
  logic [3:0]       op;
  logic [8:0]       e;
  logic [15:0]      adr [9] = '{16'h0000, 16'h003F, 16'h0040, 16'h0FFF, 16'h1000, 16'h17FF, 16'h18FF,
                                16'h1A00, 16'h8005};
  cpu_core #(.SRAM_BYTES(16'h0100)) dut (.clk(clk), .reset(reset), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata), .dreq(dreq), .drdata(drdata), .status_flags(status_flags));
  mem_model mem (.clk(clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .dreq(dreq), .drdata(drdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic emit(input logic [15:0] w);
    mem.prog[pc] = w;
    pc++;
  endtask
  // Reset is raised before a new program is written, so the old one cannot run into it.
  task automatic hold();
    @(posedge clk);
    reset <= 1'b1;
    pc = 0;
  endtask
  task automatic via_x(input logic st, input logic [4:0] rg, input logic [15:0] a, input logic [3:0] md = 4'h0);
    emit({4'h8, 4'hA, a[7:0]});
    emit({4'h8, 4'hB, a[15:8]});
    emit({4'hF, st, 2'h0, rg, md});
  endtask
  task automatic run(input int stall);
    int i;
    emit(16'h0FFF);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(pmem_addr, 16'h0000);
    for (i = 0; i < 400 && pmem_addr !== 16'(pc - 1); i++) @(negedge clk);
    check(pmem_addr, 16'(pc - 1));
    check(16'(i), 16'(pc - 1 + stall));
    if (pmem_addr !== 16'(pc - 1)) close_out();
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [8:0] alu(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b);
    case (o)
      4'h1: return {1'b0, a} + {1'b0, b};
      4'h2: return {1'b0, a} - {1'b0, b};
      4'h3: return {1'b0, a & b};
      4'h4: return {1'b0, a | b};
      4'h5: return {1'b0, a ^ b};
      default: return {1'b0, b};
    endcase
  endfunction
  initial begin
    reset = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    x = 8'($urandom(15302));
    // Equal operands first for the zero and borrow corners, then random ones.
    for (int k = 0; k < 21; k++) begin
      x = 8'($urandom);
      y = (k < 7) ? x : 8'($urandom);
      op = 4'(1 + k % 7);
      hold();
      emit({4'h8, 4'h0, x});
      emit({4'h8, 4'h1, y});
      emit({op, 2'h0, 5'h10, 5'h11});
      via_x(1'b1, (op == 4'h7) ? 5'h00 : 5'h10, 16'h1800);
      via_x(1'b1, 5'h01, 16'h1801);
      run(int'(op == 4'h7));
      e = alu(op, x, y);
      if (op == 4'h7) check({mem.dmem[16'h1801], mem.dmem[16'h1800]}, {8'h00, x} * {8'h00, y});
      if (op < 4'h7) check({8'h00, mem.dmem[16'h1800]}, {8'h00, e[7:0]});
      if (op < 4'h6) check({13'h0, status_flags[2:0] & {2'h3, op < 4'h3}}, {13'h0, e[7], e[7:0] == 8'h00, e[8] & (op < 4'h3)});
    end
    hold();
    mem.dmem[16'h8005] = 8'h5A;
    mem.dmem[16'h8123] = y;
    mem.dmem[16'h1A00] = 8'hFF;
    mem.dmem[16'h001F] = 8'h81;
    mem.dmem[16'h001E] = 8'hFF;
    emit({4'h8, 4'h2, x});
    via_x(1'b0, 5'h14, 16'h1A00);
    via_x(1'b1, 5'h14, 16'h1803);
    foreach (adr[i]) via_x(1'b1, 5'h12, adr[i]);
    via_x(1'b0, 5'h13, 16'h8123);
    via_x(1'b1, 5'h13, 16'h1802);
    emit({4'hD, 1'b1, 5'h12, 6'h3E});
    emit({4'hE, 2'h0, 2'h0, 5'h1F, 3'h3});
    emit({4'hE, 2'h1, 2'h0, 5'h1E, 3'h0});
    emit({4'hE, 2'h2, 2'h0, 5'h1E, 3'h1});
    emit({4'hD, 1'b1, 5'h12, 6'h3D});
    emit({4'hE, 2'h3, 2'h0, 5'h1E, 3'h1});
    emit({4'hD, 1'b1, 5'h12, 6'h3C});
    via_x(1'b1, 5'h12, 16'h1806, 4'h1);
    via_x(1'b0, 5'h16, 16'h1806, 4'h1);
    via_x(1'b1, 5'h17, 16'h1808);
    emit({4'h8, 4'hE, 8'h01});
    emit({4'hF, 1'b0, 2'h3, 5'h15, 4'h0});
    via_x(1'b1, 5'h15, 16'h1809);
    run(6);
    foreach (adr[i]) check({8'h00, mem.dmem[adr[i]]}, {8'h00, (i < 7) ? x : (i == 7) ? 8'hFF : 8'h5A});
    check({mem.dmem[16'h1803], mem.dmem[16'h1802]}, {8'h00, y});
    check({mem.dmem[16'h003E], mem.dmem[16'h001F]}, {x, 8'h89});
    check({8'h00, mem.dmem[16'h001E]}, 16'h00FE);
    check({mem.dmem[16'h003D], mem.dmem[16'h003C]}, {8'h00, x});
    check({mem.dmem[16'h1807], mem.dmem[16'h1806]}, {y, x});
    check({mem.dmem[16'h1809], mem.dmem[16'h1808]}, {8'h82, y});
    close_out();
  end
endmodule // tb
